// ==== core/sie_input_ctrl.sv ====
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

// One input channel: settings, ranging, reversal and pairing
module sie_channel #(
	parameter logic [23:0] HALF_FAST = sie_pkg::REV_FAST_HALF_CYC,
	parameter logic [23:0] HALF_SLOW = sie_pkg::REV_SLOW_HALF_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cfgWr,
	input wire logic [11:0] cfgWrData,
	input wire logic tcOpt,
	input wire sie_pkg::sie_sample_t sample,
	input wire logic signed [23:0] blockTemp,
	output logic [11:0] cfgOut,
	output logic [sie_pkg::STAT_W-1:0] status,
	output logic [23:0] result,
	output sie_pkg::sie_drive_t drive
);
	import sie_pkg::*;

	sie_cfg_t cfgQ, cfgD, wrCfg;
	logic [3:0] rangeQ, rangeD, wrRange, newMax, reqRange, excD, curMax;
	logic [23:0] cntQ, cntD, halfLen, mag, fsPrev, ptcLow, resultQ;
	logic signed [23:0] lastQ, posQ, curVal, readingVal, avg;
	logic signed [24:0] diff, compSum;
	logic [2:0] newType;
	logic typeOk, typeChg, newRes, newAuto, newRev, newDcur;
	logic isDiode, isPtc, isNtc, stdActive, tcActive, revOn, autoOn, ntcTop;
	logic tick, polQ, haveQ, posOkQ, validQ, curHave, pairDone, posTake;
	logic readingDone, upReq, downReq, rngUp, rngDn, rngChg, restart, compOn;
	sie_drive_t driveQ, driveD;

	// Write sanitising: reject missing option, force resistor defaults
	assign wrCfg = sie_cfg_t'(cfgWrData);
	assign typeOk = (wrCfg.sensType <= TYPE_TC) && ((wrCfg.sensType != TYPE_TC) || tcOpt);
	assign newType = typeOk ? wrCfg.sensType : cfgQ.sensType;
	assign typeChg = newType != cfgQ.sensType;
	assign newRes = (newType == TYPE_PTC) || (newType == TYPE_NTC);
	// changing to a resistor type forces autorange; none for diode
	assign newAuto = newRes && (typeChg || wrCfg.autoRange);
	assign newRev = newRes && (typeChg || wrCfg.reversal);
	assign newDcur = (newType == TYPE_DIODE) && !typeChg && wrCfg.diodeCur;
	assign newMax = sie_max_range(newType);
	assign reqRange = (wrCfg.range > newMax) ? newMax : wrCfg.range;
	// manual range only with autorange off
	assign wrRange = !newAuto ? reqRange : (typeChg ? RANGE_LOW : rangeQ);
	assign cfgD = '{units: wrCfg.units, diodeCur: newDcur, comp: wrCfg.comp,
		reversal: newRev, range: wrRange, autoRange: newAuto, sensType: newType};

	// Type decode of the live settings
	assign isDiode = cfgQ.sensType == TYPE_DIODE;
	assign isPtc = cfgQ.sensType == TYPE_PTC;
	assign isNtc = cfgQ.sensType == TYPE_NTC;
	assign stdActive = isDiode || isPtc || isNtc;
	assign tcActive = (cfgQ.sensType == TYPE_TC) && tcOpt;
	assign revOn = cfgQ.reversal && stdActive;
	assign autoOn = cfgQ.autoRange && (isPtc || isNtc);
	assign curMax = sie_max_range(cfgQ.sensType);

	// half period 10 Hz, 5 Hz on top NTC range
	assign ntcTop = isNtc && (rangeQ == MAX_RNG_NTC);
	assign halfLen = ntcTop ? HALF_SLOW : HALF_FAST;
	assign tick = revOn && (cntQ == 24'(halfLen - 24'h000001));
	assign restart = cfgWr || rngChg;
	assign cntD = (!revOn || tick || restart) ? 24'h000000 : 24'(cntQ + 24'h000001);

	// Latest sample of the current half period
	assign curVal = sample.valid ? sample.data : lastQ;
	assign curHave = sample.valid || haveQ;

	// pair positive and negative halves into a mean
	assign posTake = tick && curHave && !polQ;
	assign pairDone = tick && curHave && polQ && posOkQ;
	assign diff = 25'({posQ[23], posQ} - {curVal[23], curVal});
	assign avg = diff[24:1];
	assign readingDone = revOn ? pairDone : ((stdActive || tcActive) && sample.valid);
	assign readingVal = revOn ? avg : sample.data;

	// Autorange decisions on each finished reading
	assign mag = readingVal[23] ? 24'(-readingVal) : 24'(readingVal);
	assign fsPrev = sie_ptc_fs(4'(rangeQ - 4'h1));
	assign ptcLow = 24'(fsPrev - (fsPrev >> 3));
	// keep NTC sensor voltage below 10 mV, PTC below range full scale
	assign upReq = isNtc ? (mag >= NTC_UP_UV) : (mag > sie_ptc_fs(rangeQ));
	assign downReq = isNtc ? (mag < NTC_DOWN_UV) : (mag < ptcLow);
	assign rngUp = readingDone && autoOn && upReq && (rangeQ < curMax);
	assign rngDn = readingDone && autoOn && !upReq && downReq && (rangeQ != RANGE_LOW);
	assign rngChg = rngUp || rngDn;
	assign rangeD = cfgWr ? wrRange : rngUp ? 4'(rangeQ + 4'h1) :
		rngDn ? 4'(rangeQ - 4'h1) : rangeQ;

	// Excitation select per type and range
	// fixed 1 mA for PTC
	// NTC steps down from 1 mA
	assign excD = !stdActive ? EXC_OFF : (isPtc ? EXC_1M : isNtc ? 4'(EXC_1M - rangeQ) :
		(cfgQ.diodeCur ? EXC_1M : EXC_10U));
	assign driveD = '{stdEn: stdActive, tcEn: tcActive, polarity: polQ, range: rangeQ,
		excite: excD};

	// block offset only for temperature units
	assign compOn = tcActive && cfgQ.comp && cfgQ.units;
	assign compSum = 25'({readingVal[23], readingVal} +
		(compOn ? {blockTemp[23], blockTemp} - {NORM_TEMP[23], NORM_TEMP} : 25'h0000000));

	// Settings and range registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfgQ <= sie_cfg_t'(CFG_RESET);
			rangeQ <= RANGE_LOW;
		end else begin
			if (cfgWr) begin
				cfgQ <= cfgD;
			end
			rangeQ <= rangeD;
		end
	end

	// Reversal divider and polarity
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cntQ <= 24'h000000;
			polQ <= 1'b0;
		end else begin
			cntQ <= cntD;
			polQ <= (!revOn || cfgWr) ? 1'b0 : (tick ? !polQ : polQ);
		end
	end

	// Sample hold and pair state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lastQ <= 24'sh000000;
			haveQ <= 1'b0;
			posQ <= 24'sh000000;
			posOkQ <= 1'b0;
		end else begin
			lastQ <= curVal;
			haveQ <= (tick || restart) ? 1'b0 : curHave;
			posQ <= posTake ? curVal : posQ;
			posOkQ <= restart ? 1'b0 : (tick ? posTake : posOkQ);
		end
	end

	// Result, valid flag (set wins over clear) and drive
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resultQ <= 24'h000000;
			validQ <= 1'b0;
			driveQ <= '0;
		end else begin
			resultQ <= readingDone ? compSum[23:0] : resultQ;
			validQ <= readingDone || (validQ && !cfgWr);
			driveQ <= driveD;
		end
	end

	assign cfgOut = {cfgQ.units, cfgQ.diodeCur, cfgQ.comp, cfgQ.reversal, rangeQ,
		cfgQ.autoRange, cfgQ.sensType};
	assign status = {validQ, tcOpt, stdActive, tcActive, polQ, excD, rangeQ};
	assign result = resultQ;
	assign drive = driveQ;

	// Checks on the channel behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_ptc_fixed_exc: assert property (isPtc |-> excD == EXC_1M)
		else $error("PTC excitation not 1 mA");
	a_ptc_range_only: assert property (
		rngChg && isPtc && !cfgWr |=> isPtc && excD == $past(excD))
		else $error("PTC autorange changed excitation");
	a_ntc_exc_map: assert property (isNtc |-> excD == 4'(EXC_1M - rangeQ))
		else $error("NTC excitation does not follow range");
	a_ntc_up_step: assert property (
		readingDone && autoOn && isNtc && !cfgWr && mag >= NTC_UP_UV && rangeQ < MAX_RNG_NTC
		|=> rangeQ == 4'($past(rangeQ) + 4'h1))
		else $error("NTC range did not step up");
	a_manual_hold: assert property (
		!cfgQ.autoRange && !cfgWr |=> rangeQ == $past(rangeQ))
		else $error("Manual range moved");
	a_res_forces: assert property (
		cfgWr && newRes && typeChg |=> cfgQ.autoRange && cfgQ.reversal)
		else $error("Resistor type did not force defaults");
	a_diode_noauto: assert property (isDiode |-> !cfgQ.autoRange && rangeQ <= MAX_RNG_DIODE)
		else $error("Diode autorange or range out of limits");
	a_ntc_range_top: assert property (rangeQ <= curMax)
		else $error("Range beyond the type limit");
	a_pol_flip: assert property (tick && !cfgWr |=> polQ != $past(polQ))
		else $error("Polarity did not flip");
	a_pair_mean: assert property (pairDone |=> resultQ == $past(compSum[23:0]))
		else $error("Pair mean not stored");
	a_norev_const: assert property (!revOn |=> !polQ)
		else $error("Polarity moved with reversal off");
	a_half_slow: assert property (
		tick && ntcTop |-> $past(cntQ) == 24'(HALF_SLOW - 24'h000002))
		else $error("Slow half period wrong");
	a_tc_option: assert property (driveD.tcEn |-> tcOpt)
		else $error("Thermocouple without option");
	a_tc_exclusive: assert property (!(driveD.tcEn && driveD.stdEn))
		else $error("Both inputs enabled");
	a_tc_noexc: assert property (
		cfgQ.sensType == TYPE_TC |-> excD == EXC_OFF && rangeQ == RANGE_LOW)
		else $error("Thermocouple excited or ranged");
	a_raw_nocomp: assert property (
		readingDone && !cfgQ.units |=> resultQ == $past(readingVal))
		else $error("Raw reading compensated");

	// Range steps down, diode limits, forced reversal and compensation
	a_ntc_down_step: assert property (
		readingDone && autoOn && isNtc && !cfgWr && mag < NTC_DOWN_UV && rangeQ != RANGE_LOW
		|=> rangeQ == 4'($past(rangeQ) - 4'h1))
		else $error("NTC range did not step down");
	a_diode_ranges: assert property (
		isDiode |-> (excD == EXC_1M || excD == EXC_10U) && rangeQ <= MAX_RNG_DIODE)
		else $error("Diode excitation or range invalid");
	a_rev_forced: assert property (
		cfgWr && newRes && typeChg |=> cfgQ.reversal && !polQ)
		else $error("Resistor type did not force reversal");
	a_type_off: assert property (
		cfgQ.sensType == TYPE_OFF |-> !driveD.stdEn && !driveD.tcEn && excD == EXC_OFF)
		else $error("Disabled input still driven");
	a_comp_off: assert property (
		readingDone && !cfgQ.comp |=> resultQ == $past(readingVal))
		else $error("Compensation applied while off");
	a_comp_add: assert property (
		readingDone && compOn |=>
		resultQ == 24'($past(readingVal) + $past(blockTemp) - NORM_TEMP))
		else $error("Block temperature offset not applied");

	c_ntc_pair: cover property (pairDone && isNtc);
	c_range_up: cover property (rngUp);
	c_tc_comp: cover property (readingDone && compOn);
	c_slow_tick: cover property (tick && ntcTop);

endmodule

module sie_input_ctrl #(
	parameter logic [23:0] HALF_FAST_CYC = sie_pkg::REV_FAST_HALF_CYC,
	parameter logic [23:0] HALF_SLOW_CYC = sie_pkg::REV_SLOW_HALF_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic tcOptPresent,
	input wire logic signed [23:0] blockTemp,
	input wire sie_pkg::sie_sample_t sampleA,
	input wire sie_pkg::sie_sample_t sampleB,
	output sie_pkg::sie_drive_t driveA,
	output sie_pkg::sie_drive_t driveB
);
	import sie_pkg::*;

	logic ackQ, request, wrStrobe;
	logic selCfgA, selCfgB, selStatA, selStatB, selRdgA, selRdgB;
	logic [31:0] readdataQ, rdMux, laneMask, mergeA, mergeB;
	logic [11:0] cfgA, cfgB;
	logic [STAT_W-1:0] statA, statB;
	logic [23:0] rdgA, rdgB;

	// One wait cycle, then answer
	assign request = read || write;
	assign waitrequest = request && !ackQ;
	assign wrStrobe = write && ackQ;

	// Address decode, unmapped reads give zero
	assign selCfgA = address == OFS_CFG_A;
	assign selCfgB = address == OFS_CFG_B;
	assign selStatA = address == OFS_STAT_A;
	assign selStatB = address == OFS_STAT_B;
	assign selRdgA = address == OFS_RDG_A;
	assign selRdgB = address == OFS_RDG_B;
	assign rdMux = selCfgA ? {20'h00000, cfgA} : selCfgB ? {20'h00000, cfgB} :
		selStatA ? {19'h00000, statA} : selStatB ? {19'h00000, statB} :
		selRdgA ? {8'h00, rdgA} : selRdgB ? {8'h00, rdgB} : 32'h00000000;

	// Byte enables merge write data over current settings
	assign laneMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
		{8{byteenable[0]}}};
	assign mergeA = (writedata & laneMask) | ({20'h00000, cfgA} & ~laneMask);
	assign mergeB = (writedata & laneMask) | ({20'h00000, cfgB} & ~laneMask);

	// Bus answer registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ackQ <= 1'b0;
			readdataQ <= 32'h00000000;
		end else begin
			ackQ <= request && !ackQ;
			readdataQ <= (read && !ackQ) ? rdMux : readdataQ;
		end
	end
	assign readdata = readdataQ;

	sie_channel #(
		.HALF_FAST(HALF_FAST_CYC),
		.HALF_SLOW(HALF_SLOW_CYC)
	) chanA (
		.clk(clk),
		.nrst(nrst),
		.cfgWr(wrStrobe && selCfgA),
		.cfgWrData(mergeA[11:0]),
		.tcOpt(tcOptPresent),
		.sample(sampleA),
		.blockTemp(blockTemp),
		.cfgOut(cfgA),
		.status(statA),
		.result(rdgA),
		.drive(driveA)
	);

	sie_channel #(
		.HALF_FAST(HALF_FAST_CYC),
		.HALF_SLOW(HALF_SLOW_CYC)
	) chanB (
		.clk(clk),
		.nrst(nrst),
		.cfgWr(wrStrobe && selCfgB),
		.cfgWrData(mergeB[11:0]),
		.tcOpt(tcOptPresent),
		.sample(sampleB),
		.blockTemp(blockTemp),
		.cfgOut(cfgB),
		.status(statB),
		.result(rdgB),
		.drive(driveB)
	);

	// Bus handshake checks
	a_bus_onewait: assert property (@(posedge clk) disable iff (!nrst)
		request && !ackQ |=> !waitrequest || !request)
		else $error("Bus answer later than one wait cycle");
	// Writing input A leaves input B's settings alone
	a_chan_split: assert property (@(posedge clk) disable iff (!nrst)
		wrStrobe && selCfgA |=> $stable(cfgB[11:8]) && $stable(cfgB[3:0]))
		else $error("Channel A write changed channel B");
	c_bus_write: cover property (@(posedge clk) disable iff (!nrst) wrStrobe && selCfgB);

endmodule

`default_nettype wire

// ==== core/sie_pkg.sv ====
package sie_pkg;

	// Clock and excitation reversal timing
	localparam int CLK_HZ = 32'h02FA_F080;
	localparam int REV_FAST_HZ = 32'h0000_000A;
	localparam int REV_SLOW_HZ = 32'h0000_0005;
	localparam logic [23:0] REV_FAST_HALF_CYC = 24'(CLK_HZ / (2 * REV_FAST_HZ));
	localparam logic [23:0] REV_SLOW_HALF_CYC = 24'(CLK_HZ / (2 * REV_SLOW_HZ));

	// Register byte offsets
	localparam logic [4:0] OFS_CFG_A = 5'h00;
	localparam logic [4:0] OFS_CFG_B = 5'h04;
	localparam logic [4:0] OFS_STAT_A = 5'h08;
	localparam logic [4:0] OFS_STAT_B = 5'h0C;
	localparam logic [4:0] OFS_RDG_A = 5'h10;
	localparam logic [4:0] OFS_RDG_B = 5'h14;

	// Sensor type codes
	localparam logic [2:0] TYPE_OFF = 3'h0;
	localparam logic [2:0] TYPE_DIODE = 3'h1;
	localparam logic [2:0] TYPE_PTC = 3'h2;
	localparam logic [2:0] TYPE_NTC = 3'h3;
	localparam logic [2:0] TYPE_TC = 3'h4;

	// Highest range index per sensor type
	localparam logic [3:0] RANGE_LOW = 4'h0;
	localparam logic [3:0] MAX_RNG_DIODE = 4'h1;
	localparam logic [3:0] MAX_RNG_PTC = 4'h6;
	localparam logic [3:0] MAX_RNG_NTC = 4'h8;

	// Excitation current codes, one per 1-3-10 step
	localparam logic [3:0] EXC_OFF = 4'h0;
	localparam logic [3:0] EXC_100N = 4'h1;
	localparam logic [3:0] EXC_10U = 4'h5;
	localparam logic [3:0] EXC_1M = 4'h9;

	// Autorange thresholds in microvolts, and compensation base
	localparam logic [23:0] NTC_UP_UV = 24'h002710;
	localparam logic [23:0] NTC_DOWN_UV = 24'h0009C4;
	localparam logic signed [23:0] NORM_TEMP = 24'sh000000;

	// Configuration word, reset value and status width
	typedef struct packed {
		logic units;
		logic diodeCur;
		logic comp;
		logic reversal;
		logic [3:0] range;
		logic autoRange;
		logic [2:0] sensType;
	} sie_cfg_t;
	localparam logic [11:0] CFG_RESET = 12'hA01;
	localparam int STAT_W = 13;

	// Front end drive and sample carriers
	typedef struct packed {
		logic stdEn;
		logic tcEn;
		logic polarity;
		logic [3:0] range;
		logic [3:0] excite;
	} sie_drive_t;
	typedef struct packed {
		logic valid;
		logic signed [23:0] data;
	} sie_sample_t;

	function automatic logic [3:0] sie_max_range(input logic [2:0] t);
		case (t)
			TYPE_DIODE: sie_max_range = MAX_RNG_DIODE;
			TYPE_PTC: sie_max_range = MAX_RNG_PTC;
			TYPE_NTC: sie_max_range = MAX_RNG_NTC;
			default: sie_max_range = RANGE_LOW;
		endcase
	endfunction

	// Full scale of a fixed-current range in microvolts
	function automatic logic [23:0] sie_ptc_fs(input logic [3:0] r);
		case (r)
			4'h0: sie_ptc_fs = 24'h002710;
			4'h1: sie_ptc_fs = 24'h007530;
			4'h2: sie_ptc_fs = 24'h0186A0;
			4'h3: sie_ptc_fs = 24'h0493E0;
			4'h4: sie_ptc_fs = 24'h0F4240;
			4'h5: sie_ptc_fs = 24'h2DC6C0;
			default: sie_ptc_fs = 24'h989680;
		endcase
	endfunction

endpackage

// ==== tb/sie_front_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Behavioural analog front end: sensor voltage follows the driven excitation
module sie_front_model (
	input wire logic clk,
	input wire logic nrst,
	input wire sie_pkg::sie_drive_t drive,
	input wire logic [31:0] ohms,
	input wire logic signed [23:0] emf,
	input wire logic signed [23:0] tcUv,
	output sie_pkg::sie_sample_t sample
);
	import sie_pkg::*;
	logic [1:0] phase_q;
	logic signed [23:0] uv;
	wire go = (phase_q == 2'h2) && (drive.stdEn || drive.tcEn);

	// Excitation code to nanoamps, 1-3-10 steps from 100 nA
	function automatic int cur_na(input logic [3:0] c);
		if (c == 4'h0) return 0;
		return 100 * (10 ** ((c - 1) / 2)) * (((c - 1) % 2) ? 3 : 1);
	endfunction

	// lead offset keeps its sign, sensor term follows direction
	always_comb begin
		uv = 24'(ohms * cur_na(drive.excite) / 1000);
		uv = drive.polarity ? (emf - uv) : (uv + emf);
		if (drive.tcEn) uv = tcUv;
	end

	// Strobe every third cycle; data toggles while nothing is sampled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 2'h0;
			sample <= '0;
		end else begin
			phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
			sample.valid <= go;
			sample.data <= go ? uv : ~sample.data;
		end
	end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import sie_pkg::*;
	localparam logic [23:0] HF = 24'h000008;
	localparam logic [23:0] HS = 24'h000010;
	logic clk, nrst, read, write, waitrequest, tcOptPresent;
	logic [4:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, lastRd, ohms, expQ[$], maskQ[$];
	logic signed [23:0] blockTemp, emf, tcUv;
	sie_sample_t sampleA, sampleB;
	sie_drive_t driveA, driveB;
	int numErrors, checked, i, v, w;

	sie_input_ctrl #(.HALF_FAST_CYC(HF), .HALF_SLOW_CYC(HS)) sie_input_ctrl_i (
		.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .tcOptPresent(tcOptPresent), .blockTemp(blockTemp),
		.sampleA(sampleA), .sampleB(sampleB), .driveA(driveA), .driveB(driveB));
	sie_front_model frontA (.clk(clk), .nrst(nrst), .drive(driveA), .ohms(ohms),
		.emf(emf), .tcUv(tcUv), .sample(sampleA));
	sie_front_model frontB (.clk(clk), .nrst(nrst), .drive(driveB), .ohms(ohms),
		.emf(emf), .tcUv(tcUv), .sample(sampleB));

	// Clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic final_report;
		$display("Checks %0d errors %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic fail(input string m);
		numErrors++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask

	// Avalon master cycle: hold until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (k == 20) begin
			fail("bus hang");
			final_report;
		end
		lastRd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back(e & m);
		maskQ.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask

	// Poll a register until the masked field matches
	task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		int k;
		// Let samples taken under the old drive pass first
		repeat (3) @(posedge clk);
		for (k = 0; k < 200; k++) begin
			rd(a, 32'h0, 32'h0);
			if ((lastRd & m) === e) break;
		end
		checked++;
		if (k == 200) fail($sformatf("poll %h never reached %h", a, e));
	endtask

	// Measure one half period of the excitation square wave
	task automatic halfLen(input int e);
		int k, c;
		logic p;
		@(posedge clk);
		p = driveA.polarity;
		for (k = 0; k < 100 && driveA.polarity === p; k++) @(posedge clk);
		p = driveA.polarity;
		c = 0;
		for (k = 0; k < 100 && driveA.polarity === p; k++) begin
			@(posedge clk);
			c++;
		end
		checked++;
		if (c != e) fail($sformatf("half period %0d", c));
	endtask

	// Read monitor: compare each completed read that has a nonzero mask with the oldest note
	always @(posedge clk) begin
		if (read === 1'b1 && waitrequest === 1'b0) begin
			if (expQ.size() == 0) fail("read without expectation");
			else if (maskQ[0] != 0) begin
				checked++;
				if ((readdata & maskQ[0]) !== expQ[0])
					fail($sformatf("addr %h read %h exp %h", address, readdata, expQ[0]));
			end
			if (expQ.size() != 0) begin
				void'(expQ.pop_front());
				void'(maskQ.pop_front());
			end
		end
	end

	// Main sequence
	initial begin
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		byteenable = 4'hF;
		tcOptPresent = 1'b0;
		blockTemp = 24'sh000000;
		emf = 24'sd700;
		tcUv = 24'sh000000;
		ohms = 32'd5;
		numErrors = 0;
		checked = 0;
		void'($urandom(19));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(OFS_CFG_A, 32'hA01, 32'hFFF);
		rd(OFS_CFG_B, 32'hA01, 32'hFFF);
		rd(OFS_STAT_A, 32'h450, 32'h7FF);
		v = 1 + ($urandom % 9);
		ohms <= 32'(v);
		wr(OFS_CFG_A, 32'hA02);
		rd(OFS_CFG_A, 32'hB0A, 32'hFFF);
		rd(OFS_STAT_A, 32'h490, 32'h4FF);
		halfLen(int'(HF));
		poll(OFS_STAT_A, 32'h1000, 32'h1000);
		rd(OFS_RDG_A, 32'(v * 1000), 32'hFFFFFF);
		wr(OFS_CFG_A, 32'hA0A);
		w = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			// First edge still shows the drive from before the write
			if (i > 0 && driveA.polarity !== 1'b0) w = 1;
		end
		checked++;
		if (w == 1) fail("polarity moved with reversal off");
		poll(OFS_STAT_A, 32'h1000, 32'h1000);
		rd(OFS_RDG_A, 32'(v * 1000 + 700), 32'hFFFFFF);
		wr(OFS_CFG_A, 32'hA32);
		rd(OFS_CFG_A, 32'hA32, 32'hFFF);
		rd(OFS_STAT_A, 32'h493, 32'h4FF);
		wr(OFS_CFG_A, 32'hA92);
		rd(OFS_CFG_A, 32'hA62, 32'hFFF);
		wr(OFS_CFG_A, 32'hA03);
		for (i = 0; i < 9; i++) begin
			wr(OFS_CFG_A, 32'hA03 | 32'(i << 4));
			rd(OFS_STAT_A, 32'h400 | 32'((9 - i) << 4) | 32'(i), 32'h4FF);
		end
		wr(OFS_CFG_A, 32'hB83);
		halfLen(int'(HS));
		wr(OFS_CFG_A, 32'hA09);
		rd(OFS_CFG_A, 32'hA01, 32'hFFF);
		for (i = 0; i < 4; i++) begin
			wr(OFS_CFG_A, 32'hA09 | 32'((i & 1) << 4) | 32'((i >> 1) << 10));
			rd(OFS_CFG_A, 32'hA01 | 32'((i & 1) << 4) | 32'((i >> 1) << 10), 32'hFFF);
			rd(OFS_STAT_A, 32'h400 | ((i > 1) ? 32'h90 : 32'h50) | 32'(i & 1), 32'h4FF);
		end
		ohms <= 32'd2000;
		wr(OFS_CFG_A, 32'hA03);
		poll(OFS_STAT_A, 32'hFF, 32'h45);
		ohms <= 32'd200;
		poll(OFS_STAT_A, 32'hFF, 32'h63);
		wr(OFS_CFG_A, 32'hA04);
		rd(OFS_CFG_A, 32'h3, 32'h7);
		v = $urandom % 4096;
		w = $urandom % 1024;
		tcOptPresent <= 1'b1;
		tcUv <= 24'(v);
		blockTemp <= 24'(w);
		wr(OFS_CFG_A, 32'hA04);
		rd(OFS_STAT_A, 32'hA00, 32'hEFF);
		poll(OFS_STAT_A, 32'h1000, 32'h1000);
		rd(OFS_RDG_A, 32'(v + w), 32'hFFFFFF);
		wr(OFS_CFG_A, 32'h204);
		poll(OFS_STAT_A, 32'h1000, 32'h1000);
		rd(OFS_RDG_A, 32'(v), 32'hFFFFFF);
		wr(OFS_CFG_A, 32'h804);
		poll(OFS_STAT_A, 32'h1000, 32'h1000);
		rd(OFS_RDG_A, 32'(v), 32'hFFFFFF);
		wr(OFS_CFG_B, 32'hA03);
		rd(OFS_CFG_B, 32'hB0B, 32'hF0F);
		poll(OFS_STAT_B, 32'hFF, 32'h63);
		checked++;
		if (driveB.range !== 4'h3 || driveB.excite !== 4'h6) fail("channel B drive");
		rd(OFS_CFG_A, 32'h804, 32'hFFF);
		wr(OFS_STAT_A, 32'hFFF);
		rd(OFS_STAT_A, 32'hA00, 32'hEFF);
		wr(5'h18, 32'hFFF);
		rd(5'h18, 32'h0, 32'hFFFFFFFF);
		wr(OFS_CFG_B, 32'hA00);
		rd(OFS_STAT_B, 32'h800, 32'hEFF);
		// Mid-run reset returns both inputs to their defaults
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(OFS_CFG_A, 32'hA01, 32'hFFF);
		rd(OFS_CFG_B, 32'hA01, 32'hFFF);
		final_report;
	end
endmodule

`default_nettype wire
